/* hw/odt_pkg.sv */
package odt_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         CLK_PER_MC = 2;
  localparam logic [2:0] MC_ONE     = 3'h1;
  localparam logic [2:0] MC_TWO     = 3'h2;
  localparam logic [2:0] MC_FOUR    = 3'h4;
  localparam logic [2:0] CNT_ZERO   = 3'h0;

  // ----------------------------------------
  // Instruction lengths
  // ----------------------------------------
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // ----------------------------------------
  // Reset values and selects
  // ----------------------------------------
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [3:0]  EXT_SEL_STORE = 4'h1;

  // ----------------------------------------
  // Opcodes named by the decoder and the sequencer
  // ----------------------------------------
  localparam logic [7:0] OPC_MUL     = 8'ha4;
  localparam logic [7:0] OPC_DIV     = 8'h84;
  localparam logic [7:0] OPC_EXT     = 8'ha5;
  localparam logic [7:0] OPC_CJNE_AI = 8'hb4;
  localparam logic [7:0] OPC_CJNE_AD = 8'hb5;

  // ----------------------------------------
  // Operation classes
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_OTHER, OP_AJMP, OP_ACALL, OP_LJMP, OP_LCALL, OP_SJMP,
    OP_JC, OP_JNC, OP_JB, OP_JNB, OP_JBC, OP_JZ, OP_JNZ, OP_JMPI,
    OP_CJNE, OP_DJNZ, OP_SWAP, OP_RL, OP_RLC, OP_RR, OP_RRC,
    OP_XCHD, OP_ANLNC, OP_ORLNC, OP_STORE, OP_TRAP
  } odt_op_e;

endpackage

/* hw/odt_decode.sv */
`timescale 1ns/1ps
module odt_decode (
  // Opcode in
  input  wire logic [7:0]  opcode,
  input  wire logic [3:0]  ext_sel,
  // Decoded fields
  output odt_pkg::odt_op_e op,
  output logic [1:0]       len,
  output logic [2:0]       mcyc,
  output logic [2:0]       reg_sel
);
  import odt_pkg::*;

  // Working register from low three bits
  assign reg_sel = opcode[2:0];

  // Instruction length
  always_comb begin
    casez (opcode)
      8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h75, 8'h90: len = LEN_3;
      8'h43, 8'h53, 8'h63: len = LEN_3;
      8'h85: len = LEN_3;
      8'hb4, 8'hb5, 8'b1011_011?, 8'b1011_1???: len = LEN_3;
      8'hd5, 8'b1101_1???: len = LEN_3;
      8'b????0001: len = LEN_2;
      8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94: len = LEN_2;
      8'h05, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55, 8'h65: len = LEN_2;
      8'h95, 8'hc5, 8'he5, 8'hf5: len = LEN_2;
      8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92: len = LEN_2;
      8'ha2, 8'hb2, 8'hc2, 8'hd2: len = LEN_2;
      8'h40, 8'h50, 8'h60, 8'h70, 8'h80: len = LEN_2;
      8'ha0, 8'hb0: len = LEN_2;
      8'hc0, 8'hd0: len = LEN_2;
      8'h76, 8'h77, 8'h86, 8'h87, 8'ha6, 8'ha7: len = LEN_2;
      8'b0111_1???, 8'b1000_1???, 8'b1010_1???: len = LEN_2;
      default: len = LEN_1;
    endcase
  end

  // Execution time in machine cycles
  always_comb begin
    casez (opcode)
      OPC_MUL, OPC_DIV: mcyc = MC_FOUR;
      OPC_EXT: mcyc = (ext_sel == EXT_SEL_STORE) ? MC_TWO : MC_ONE;
      8'b????0001, 8'h02, 8'h12, 8'h22, 8'h32, 8'h73: mcyc = MC_TWO;
      8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80: mcyc = MC_TWO;
      8'hb4, 8'hb5, 8'b1011_011?, 8'b1011_1???: mcyc = MC_TWO;
      8'hd5, 8'b1101_1???: mcyc = MC_TWO;
      8'h43, 8'h53, 8'h63: mcyc = MC_TWO;
      8'h83, 8'h93: mcyc = MC_TWO;
      8'b1110_00??, 8'b1111_00??: mcyc = MC_TWO;
      8'hc0, 8'hd0: mcyc = MC_TWO;
      8'h85: mcyc = MC_TWO;
      8'ha3, 8'h86, 8'h87, 8'h75, 8'h90, 8'ha6, 8'ha7: mcyc = MC_TWO;
      8'b1000_1???, 8'b1010_1???: mcyc = MC_TWO;
      8'h82, 8'h72, 8'h92, 8'hb0, 8'ha0: mcyc = MC_TWO;
      default: mcyc = MC_ONE;
    endcase
  end

  // Operation class
  always_comb begin
    casez (opcode)
      8'b???00001: op = OP_AJMP;
      8'b???10001: op = OP_ACALL;
      8'h02: op = OP_LJMP;
      8'h12: op = OP_LCALL;
      8'h80: op = OP_SJMP;
      8'h40: op = OP_JC;
      8'h50: op = OP_JNC;
      8'h20: op = OP_JB;
      8'h30: op = OP_JNB;
      8'h10: op = OP_JBC;
      8'h60: op = OP_JZ;
      8'h70: op = OP_JNZ;
      8'h73: op = OP_JMPI;
      8'hb4, 8'hb5, 8'b1011_011?, 8'b1011_1???: op = OP_CJNE;
      8'hd5, 8'b1101_1???: op = OP_DJNZ;
      8'hc4: op = OP_SWAP;
      8'h23: op = OP_RL;
      8'h33: op = OP_RLC;
      8'h03: op = OP_RR;
      8'h13: op = OP_RRC;
      8'b1101_011?: op = OP_XCHD;
      8'hb0: op = OP_ANLNC;
      8'ha0: op = OP_ORLNC;
      OPC_EXT: op = (ext_sel == EXT_SEL_STORE) ? OP_STORE : OP_TRAP;
      default: op = OP_OTHER;
    endcase
  end

endmodule

/* hw/odt_core.sv */
`timescale 1ns/1ps
module odt_core (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Program memory fetch
  output logic [15:0]      code_addr,
  output logic             code_rd,
  input  wire logic [7:0]  code_rdata,
  // Extension select and operands
  input  wire logic [3:0]  extension_opcode_select,
  input  wire logic [7:0]  acc_in,
  input  wire logic [15:0] dptr_in,
  input  wire logic        carry_in,
  input  wire logic        bit_in,
  input  wire logic [7:0]  mem_in,
  // Timing
  output logic             mc_tick,
  output logic             instr_done,
  // Decoded instruction
  output logic [7:0]       opcode_out,
  output logic [7:0]       operand1_out,
  output logic [7:0]       operand2_out,
  output odt_pkg::odt_op_e op_out,
  output logic [2:0]       reg_sel_out,
  output logic [1:0]       len_out,
  output logic [2:0]       mcyc_out,
  // Results
  output logic [7:0]       acc_out,
  output logic [7:0]       mem_out,
  output logic             carry_out,
  output logic             bit_clear,
  output logic             branch_taken,
  output logic [15:0]      target_out,
  output logic [15:0]      dptr_out,
  output logic             prog_wr,
  output logic             trap
);
  import odt_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic {ST_IDLE, ST_RUN} odt_st_e;

  typedef struct packed {
    odt_st_e     st;
    logic [2:0]  cnt;
    logic [15:0] pc;
    logic [15:0] start_pc;
    logic [7:0]  opc;
    logic [7:0]  op1;
    logic [7:0]  op2;
    odt_op_e     op;
    logic [1:0]  len;
    logic [2:0]  mcyc;
    logic [2:0]  rsel;
    logic        done;
    logic [7:0]  acc;
    logic [7:0]  mem;
    logic        cy;
    logic        bclr;
    logic        taken;
    logic [15:0] tgt;
    logic [15:0] dptr;
    logic        pwr;
    logic        trap;
  } odt_state_s;

  odt_state_s s_reg;
  odt_state_s s_next;

  // Last clock of an instruction of mc machine cycles
  function automatic logic [2:0] last_cnt(input logic [2:0] mc);
    return 3'(CLK_PER_MC * int'(mc) - 1);
  endfunction

  // ----------------------------------------
  // Decode of the byte on the fetch bus
  // ----------------------------------------
  odt_op_e     dec_op;
  logic [1:0]  dec_len;
  logic [2:0]  dec_mcyc;
  logic [2:0]  dec_rsel;

  odt_decode u_decode (
    .opcode  (code_rdata),
    .ext_sel (extension_opcode_select),
    .op      (dec_op),
    .len     (dec_len),
    .mcyc    (dec_mcyc),
    .reg_sel (dec_rsel)
  );

  // Sequencer strobes
  logic        run;
  logic        fetch;
  logic        is_last;
  logic [7:0]  op1_w;
  logic [7:0]  rel;
  logic [15:0] base;
  logic [15:0] rel_tgt;

  assign run     = (s_reg.st == ST_RUN);
  assign fetch   = run && ((s_reg.cnt == CNT_ZERO) || (s_reg.cnt < {1'b0, s_reg.len}));
  assign is_last = run && (s_reg.cnt != CNT_ZERO) && (s_reg.cnt == last_cnt(s_reg.mcyc));
  assign op1_w   = (s_reg.cnt == 3'h1) ? code_rdata : s_reg.op1;
  assign base    = s_reg.start_pc + {14'h0000, s_reg.len};
  assign rel     = (s_reg.len == LEN_3) ? s_reg.op2 : op1_w;
  assign rel_tgt = base + {{8{rel[7]}}, rel};

  // ----------------------------------------
  // Next state and execute
  // ----------------------------------------
  always_comb begin
    logic       brel;
    logic       cond;
    logic [7:0] lhs;
    logic [7:0] rhs;
    brel   = 1'b0;
    cond   = 1'b0;
    lhs    = mem_in;
    rhs    = s_reg.op1;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.pwr  = 1'b0;
    s_next.trap = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.st  = ST_RUN;
        s_next.cnt = CNT_ZERO;
      end
      ST_RUN: begin
        // Byte capture and counter
        if (fetch) begin
          s_next.pc = s_reg.pc + 16'h0001;
        end
        if (s_reg.cnt == CNT_ZERO) begin
          s_next.start_pc = s_reg.pc;
          s_next.opc      = code_rdata;
          s_next.op       = dec_op;
          s_next.len      = dec_len;
          s_next.mcyc     = dec_mcyc;
          s_next.rsel     = dec_rsel;
        end else if (fetch && (s_reg.cnt == 3'h1)) begin
          s_next.op1 = code_rdata;
        end else if (fetch) begin
          s_next.op2 = code_rdata;
        end
        s_next.cnt = is_last ? CNT_ZERO : s_reg.cnt + 3'h1;
        if (is_last) begin
          // Results default to pass-through
          s_next.done  = 1'b1;
          s_next.acc   = acc_in;
          s_next.mem   = mem_in;
          s_next.cy    = carry_in;
          s_next.bclr  = 1'b0;
          s_next.taken = 1'b0;
          s_next.tgt   = base;
          s_next.dptr  = dptr_in;
          case (s_reg.op)
            OP_AJMP, OP_ACALL: begin
              s_next.taken = 1'b1;
              s_next.tgt   = {base[15:11], s_reg.opc[7:5], op1_w};
            end
            OP_LJMP, OP_LCALL: begin
              s_next.taken = 1'b1;
              s_next.tgt   = {s_reg.op1, s_reg.op2};
            end
            OP_SJMP: begin
              brel = 1'b1;
              cond = 1'b1;
            end
            OP_JC: begin
              brel = 1'b1;
              cond = carry_in;
            end
            OP_JNC: begin
              brel = 1'b1;
              cond = !carry_in;
            end
            OP_JB: begin
              brel = 1'b1;
              cond = bit_in;
            end
            OP_JNB: begin
              brel = 1'b1;
              cond = !bit_in;
            end
            OP_JBC: begin
              brel = 1'b1;
              cond = bit_in;
              s_next.bclr = bit_in;
            end
            OP_JZ: begin
              brel = 1'b1;
              cond = (acc_in == 8'h00);
            end
            OP_JNZ: begin
              brel = 1'b1;
              cond = (acc_in != 8'h00);
            end
            OP_JMPI: begin
              s_next.taken = 1'b1;
              s_next.tgt   = dptr_in + {8'h00, acc_in};
            end
            OP_CJNE: begin
              if ((s_reg.opc == OPC_CJNE_AI) || (s_reg.opc == OPC_CJNE_AD)) begin
                lhs = acc_in;
              end
              if (s_reg.opc == OPC_CJNE_AD) begin
                rhs = mem_in;
              end
              brel = 1'b1;
              cond = (lhs != rhs);
              s_next.cy = (lhs < rhs);
            end
            OP_DJNZ: begin
              brel = 1'b1;
              cond = (mem_in != 8'h01);
              s_next.mem = mem_in - 8'h01;
            end
            OP_SWAP: s_next.acc = {acc_in[3:0], acc_in[7:4]};
            OP_RL:   s_next.acc = {acc_in[6:0], acc_in[7]};
            OP_RR:   s_next.acc = {acc_in[0], acc_in[7:1]};
            OP_RLC: begin
              s_next.acc = {acc_in[6:0], carry_in};
              s_next.cy  = acc_in[7];
            end
            OP_RRC: begin
              s_next.acc = {carry_in, acc_in[7:1]};
              s_next.cy  = acc_in[0];
            end
            OP_XCHD: begin
              s_next.acc = {acc_in[7:4], mem_in[3:0]};
              s_next.mem = {mem_in[7:4], acc_in[3:0]};
            end
            OP_ANLNC: s_next.cy = carry_in & !bit_in;
            OP_ORLNC: s_next.cy = carry_in | !bit_in;
            OP_STORE: begin
              s_next.pwr  = 1'b1;
              s_next.dptr = dptr_in + 16'h0001;
            end
            OP_TRAP: s_next.trap = 1'b1;
            default: s_next.taken = 1'b0;
          endcase
          // Relative branches resolve against the next instruction
          if (brel) begin
            s_next.taken = cond;
            s_next.tgt   = cond ? rel_tgt : base;
          end
          s_next.pc = s_next.taken ? s_next.tgt : s_next.pc;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_reg    <= '0;
      s_reg.pc <= PC_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign code_addr    = s_reg.pc;
  assign code_rd      = fetch;
  assign mc_tick      = run && !s_reg.cnt[0];
  assign instr_done   = s_reg.done;
  assign opcode_out   = s_reg.opc;
  assign operand1_out = s_reg.op1;
  assign operand2_out = s_reg.op2;
  assign op_out       = s_reg.op;
  assign reg_sel_out  = s_reg.rsel;
  assign len_out      = s_reg.len;
  assign mcyc_out     = s_reg.mcyc;
  assign acc_out      = s_reg.acc;
  assign mem_out      = s_reg.mem;
  assign carry_out    = s_reg.cy;
  assign bit_clear    = s_reg.bclr;
  assign branch_taken = s_reg.taken;
  assign target_out   = s_reg.tgt;
  assign dptr_out     = s_reg.dptr;
  assign prog_wr      = s_reg.pwr;
  assign trap         = s_reg.trap;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [2:0] fc;
  logic [2:0] dur;

  // Fetches and clocks within one instruction
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fc  <= 3'h0;
      dur <= 3'h0;
    end else if (is_last || !run) begin
      fc  <= 3'h0;
      dur <= 3'h0;
    end else begin
      fc  <= fc + {2'h0, fetch};
      dur <= dur + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_exec;
    is_last;
  endsequence

  sequence s_done;
    instr_done ##1 !instr_done;
  endsequence

  property p_exec_done;
    s_exec |=> s_done;
  endproperty
  a_exec_done: assert property (p_exec_done) else $error("no done pulse");

  property p_fetch_len;
    is_last |-> (fc + {2'h0, fetch}) == {1'b0, s_reg.len};
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("fetch count wrong");

  property p_dur;
    is_last |-> (dur == 3'(CLK_PER_MC * int'(s_reg.mcyc) - 1)) && !mc_tick;
  endproperty
  a_dur: assert property (p_dur) else $error("duration wrong");

  property p_muldiv;
    instr_done && ((opcode_out == OPC_MUL) || (opcode_out == OPC_DIV)) |-> mcyc_out == MC_FOUR;
  endproperty
  a_muldiv: assert property (p_muldiv) else $error("mul/div not four");

  property p_regsel;
    instr_done && (opcode_out[7:3] == 5'h1d) |-> reg_sel_out == opcode_out[2:0];
  endproperty
  a_regsel: assert property (p_regsel) else $error("register select");

  property p_abs;
    instr_done && ((op_out == OP_AJMP) || (op_out == OP_ACALL)) |->
      branch_taken && (target_out[10:8] == opcode_out[7:5]);
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target");

  property p_swap;
    instr_done && (op_out == OP_SWAP) |-> acc_out == {$past(acc_in[3:0]), $past(acc_in[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap result");

  property p_xchd;
    instr_done && (op_out == OP_XCHD) |-> acc_out[7:4] == $past(acc_in[7:4]) && mcyc_out == MC_ONE;
  endproperty
  a_xchd: assert property (p_xchd) else $error("nibble exchange");

  property p_anlc;
    instr_done && (op_out == OP_ANLNC) |-> carry_out == ($past(carry_in) && !$past(bit_in));
  endproperty
  a_anlc: assert property (p_anlc) else $error("carry and-not");

  property p_jbc;
    instr_done && (op_out == OP_JBC) |-> (branch_taken == $past(bit_in)) && (bit_clear == $past(bit_in));
  endproperty
  a_jbc: assert property (p_jbc) else $error("jump and clear");

  property p_long;
    instr_done && (op_out == OP_LJMP) |-> target_out == {operand1_out, operand2_out};
  endproperty
  a_long: assert property (p_long) else $error("long target");

  property p_ind;
    instr_done && (op_out == OP_JMPI) |-> target_out == $past(dptr_in) + {8'h00, $past(acc_in)};
  endproperty
  a_ind: assert property (p_ind) else $error("indirect target");

  property p_store;
    instr_done && (op_out == OP_STORE) |-> prog_wr && dptr_out == $past(dptr_in) + 16'h0001;
  endproperty
  a_store: assert property (p_store) else $error("store increment");

  property p_rel;
    instr_done && (op_out == OP_SJMP) |->
      target_out == s_reg.start_pc + 16'h0002 + {{8{operand1_out[7]}}, operand1_out};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target");

endmodule

/* bench/odt_mem_model.sv */
`timescale 1ns/1ps
module odt_mem_model (
  // Fetch port
  input  wire logic [15:0] code_addr,
  input  wire logic        code_rd,
  output logic [7:0]       code_rdata
);
  logic [7:0] mem [65536];

  // Unwritten space reads as no-operation
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
  end

  // Same-cycle answer; inverted byte when no fetch is taken
  assign code_rdata = code_rd ? mem[code_addr] : ~mem[code_addr];
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import odt_pkg::*;

  typedef struct {
    logic [7:0]  opc;
    logic [1:0]  len;
    logic [2:0]  mc;
    odt_op_e     op;
    logic [7:0]  acc;
    logic [7:0]  mem;
    logic        cy;
    logic        cyk;
    logic        bclr;
    logic        br;
    logic [15:0] tgt;
    logic [15:0] dp;
    logic        pw;
    logic        tr;
    logic [7:0]  o1;
    logic [7:0]  o2;
  } odt_exp_s;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_sys;
  logic        rst_b;
  logic [15:0] code_addr, dptr_in, target_out, dptr_out, pc, dptr_v;
  logic        code_rd, carry_in, bit_in, mc_tick, instr_done, carry_out, bit_clear;
  logic        branch_taken, prog_wr, trap, cy_v, bit_v, first;
  logic [7:0]  code_rdata, acc_in, mem_in, opcode_out, operand1_out, operand2_out;
  logic [7:0]  acc_out, mem_out, acc_v, mem_v;
  logic [3:0]  extension_opcode_select, sel_v;
  logic [2:0]  reg_sel_out, mcyc_out;
  logic [1:0]  len_out;
  odt_op_e     op_out;
  odt_exp_s    e, em;
  odt_exp_s    exp_q [$];
  integer      seed = 32'hab8ce9c4;
  int          mismatches, n_tests, n_rd, n_cy, n_mc;

  // Plain one- to four-cycle opcodes: opcode, length, machine cycles
  localparam logic [15:0] SIMPLE [16] = '{16'h2811, 16'h3f11, 16'h9a11, 16'heb11, 16'h5332, 16'h4332,
    16'h6332, 16'h9312, 16'h8312, 16'he012, 16'hf012, 16'h8532, 16'hc022, 16'hd022, 16'ha414, 16'h8414};

  odt_core dut (.clk_sys, .rst_b, .code_addr, .code_rd, .code_rdata, .extension_opcode_select, .acc_in,
    .dptr_in, .carry_in, .bit_in, .mem_in, .mc_tick, .instr_done, .opcode_out, .operand1_out, .operand2_out,
    .op_out, .reg_sel_out, .len_out, .mcyc_out, .acc_out, .mem_out, .carry_out, .bit_clear, .branch_taken,
    .target_out, .dptr_out, .prog_wr, .trap);

  odt_mem_model mdl (.code_addr, .code_rd, .code_rdata);

  // Clock
  always #25 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Program builder
  // ----------------------------------------
  function automatic logic [15:0] rel_t(input logic [1:0] ln, input logic [7:0] rl);
    return pc + 16'(ln) + {{8{rl[7]}}, rl};
  endfunction

  task automatic emit(input logic [7:0] b0, b1, b2, input logic [1:0] ln, input logic [2:0] mc, input odt_op_e op);
    mdl.mem[pc] = b0;
    mdl.mem[pc + 16'h1] = b1;
    mdl.mem[pc + 16'h2] = b2;
    e = '{b0, ln, mc, op, acc_v, mem_v, cy_v, 1'b0, 1'b0, 1'b0, pc + 16'(ln), dptr_v, 1'b0, 1'b0, b1, b2};
  endtask

  task automatic put();
    exp_q.push_back(e);
    pc = e.br ? e.tgt : pc + 16'(e.len);
  endtask

  task automatic build(input logic [3:0] sel);
    logic [7:0] r;
    logic [7:0] rl;
    logic       st;
    r = 8'($random(seed));
    rl = {5'h0, r[2:0]} + 8'h1;
    st = (sel == EXT_SEL_STORE);
    pc = PC_RESET;
    foreach (SIMPLE[i]) begin
      emit(SIMPLE[i][15:8], r, rl, SIMPLE[i][5:4], SIMPLE[i][2:0], OP_OTHER);
      put();
    end
    emit(8'hc4, r, r, LEN_1, MC_ONE, OP_SWAP);
    e.acc = {acc_v[3:0], acc_v[7:4]};
    put();
    emit(8'h23, r, r, LEN_1, MC_ONE, OP_RL);
    e.acc = {acc_v[6:0], acc_v[7]};
    put();
    emit(8'h33, r, r, LEN_1, MC_ONE, OP_RLC);
    e.acc = {acc_v[6:0], cy_v};
    e.cy = acc_v[7];
    e.cyk = 1'b1;
    put();
    emit(8'h03, r, r, LEN_1, MC_ONE, OP_RR);
    e.acc = {acc_v[0], acc_v[7:1]};
    put();
    emit(8'h13, r, r, LEN_1, MC_ONE, OP_RRC);
    e.acc = {cy_v, acc_v[7:1]};
    e.cy = acc_v[0];
    e.cyk = 1'b1;
    put();
    emit(8'hd6, r, r, LEN_1, MC_ONE, OP_XCHD);
    e.acc = {acc_v[7:4], mem_v[3:0]};
    e.mem = {mem_v[7:4], acc_v[3:0]};
    put();
    emit(8'hb0, r, r, LEN_2, MC_TWO, OP_ANLNC);
    e.cy = cy_v & ~bit_v;
    e.cyk = 1'b1;
    put();
    emit(8'ha0, r, r, LEN_2, MC_TWO, OP_ORLNC);
    e.cy = cy_v | ~bit_v;
    e.cyk = 1'b1;
    put();
    emit(8'h10, r, rl, LEN_3, MC_TWO, OP_JBC);
    e.br = bit_v;
    e.bclr = bit_v;
    e.tgt = bit_v ? rel_t(LEN_3, rl) : e.tgt;
    put();
    emit(8'h80, rl, r, LEN_2, MC_TWO, OP_SJMP);
    e.br = 1'b1;
    e.tgt = rel_t(LEN_2, rl);
    put();
    emit(8'hba, cy_v ? mem_v : r, rl, LEN_3, MC_TWO, OP_CJNE);
    e.br = (mem_v != (cy_v ? mem_v : r));
    e.cy = (mem_v < (cy_v ? mem_v : r));
    e.cyk = 1'b1;
    e.tgt = e.br ? rel_t(LEN_3, rl) : e.tgt;
    put();
    emit(8'hd5, r, rl, LEN_3, MC_TWO, OP_DJNZ);
    e.mem = mem_v - 8'h1;
    e.br = (e.mem != 8'h00);
    e.tgt = e.br ? rel_t(LEN_3, rl) : e.tgt;
    put();
    emit(8'h70, rl, r, LEN_2, MC_TWO, OP_JNZ);
    e.br = (acc_v != 8'h00);
    e.tgt = e.br ? rel_t(LEN_2, rl) : e.tgt;
    put();
    // Long jump lands clear of the code laid down so far
    emit(8'h02, 8'h01, 8'h40 + r[3:0], LEN_3, MC_TWO, OP_LJMP);
    e.br = 1'b1;
    e.tgt = {8'h01, 8'h40 + r[3:0]};
    put();
    emit(8'hf1, r, r, LEN_2, MC_TWO, OP_ACALL);
    e.br = 1'b1;
    e.tgt = {e.tgt[15:11], 3'h7, r};
    put();
    emit(8'ha5, r, r, LEN_1, st ? MC_TWO : MC_ONE, st ? OP_STORE : OP_TRAP);
    e.pw = st;
    e.tr = !st;
    e.dp = st ? dptr_v + 16'h1 : dptr_v;
    put();
    emit(8'h73, r, r, LEN_1, MC_TWO, OP_JMPI);
    e.br = 1'b1;
    e.tgt = dptr_v + {8'h00, acc_v};
    put();
  endtask

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic check_one();
    em = exp_q.pop_front();
    chk("opcode", em.opc, opcode_out);
    chk("len", em.len, len_out);
    chk("addr", em.tgt, code_addr);
    if (em.len != LEN_1) begin
      chk("operand1", em.o1, operand1_out);
    end
    if (em.len == LEN_3) begin
      chk("operand2", em.o2, operand2_out);
    end
    chk("fetches", em.len, n_rd);
    chk("mcyc", em.mc, mcyc_out);
    if (!first) begin
      chk("clocks", 2 * em.mc, n_cy);
      chk("ticks", em.mc, n_mc);
    end
    chk("op", em.op, op_out);
    chk("reg", em.opc[2:0], reg_sel_out);
    chk("acc", em.acc, acc_out);
    chk("mem", em.mem, mem_out);
    if (em.cyk) begin
      chk("carry", em.cy, carry_out);
    end
    chk("bitclr", em.bclr, bit_clear);
    chk("taken", em.br, branch_taken);
    chk("target", em.tgt, target_out);
    chk("dptr", em.dp, dptr_out);
    chk("store", em.pw, prog_wr);
    chk("trap", em.tr, trap);
  endtask

  // Watches completions and counts fetches, clocks and ticks per instruction
  always @(negedge clk_sys) begin
    if (rst_b !== 1'b1) begin
      first = 1'b1;
      n_rd = 0;
      n_cy = 0;
      n_mc = 0;
    end else begin
      if (instr_done === 1'b1) begin
        if (exp_q.size() > 0) begin
          check_one();
        end
        first = 1'b0;
        n_rd = 0;
        n_cy = 0;
        n_mc = 0;
      end
      n_rd += int'(code_rd === 1'b1);
      n_cy += 1;
      n_mc += int'(mc_tick === 1'b1);
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic run(input logic ph);
    int k;
    @(posedge clk_sys);
    rst_b <= 1'b0;
    acc_v = 8'($random(seed));
    mem_v = 8'($random(seed));
    dptr_v = {1'b1, 15'($random(seed))};
    cy_v = ph;
    bit_v = !ph;
    sel_v = ph ? (4'($random(seed)) | 4'h2) : EXT_SEL_STORE;
    acc_in <= acc_v;
    mem_in <= mem_v;
    dptr_in <= dptr_v;
    carry_in <= cy_v;
    bit_in <= bit_v;
    extension_opcode_select <= sel_v;
    build(sel_v);
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (k = 0; k < 3000 && exp_q.size() > 0; k++) begin
      @(posedge clk_sys);
    end
    if (exp_q.size() > 0) begin
      mismatches++;
      $display("FAIL completion expected %0d seen %0d", 0, exp_q.size());
      conclude();
    end
  endtask

  // Two passes: store then break, with a reset in mid-run between
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    extension_opcode_select = 4'h0;
    acc_in = 8'h00;
    mem_in = 8'h00;
    dptr_in = 16'h0000;
    carry_in = 1'b0;
    bit_in = 1'b0;
    run(1'b0);
    run(1'b1);
    conclude();
  end
endmodule
